// file: rtl/reset_res_pkg.sv
// Purpose: constants and carrier types for the hub reset resource handler
// Assumes: one long-message request at a time, presented as a one-cycle strobe
// Notes: resource name strings are held as 8 ASCII bytes, first character in the top byte
package reset_res_pkg;
   localparam logic [11:0] device_reset_id = 12'h100;
   localparam logic [11:0] plain_reset_id = 12'h210;
   localparam logic [11:0] factory_reset_id = 12'h218;
   localparam logic [6:0] qual_count = 7'h06;
   localparam int offset_sel_width = 7;
   // error codes: class byte then detail byte
   localparam logic [15:0] err_bad_offset = 16'h1340;
   localparam logic [15:0] err_no_direct_write = 16'h1441;
   localparam logic [15:0] err_no_indirect_read = 16'h1141;
   localparam logic [15:0] err_low_level = 16'h1241;
   localparam logic [15:0] err_bad_data = 16'h1441;
   localparam logic [3:0] factory_write_level = 4'h2;
   localparam logic [63:0] factory_reset_code_word = 64'h5245534554414c4c;
   // qualifiers of the plain reset resource
   localparam logic [63:0] plain_reset_resource_label = 64'h53485f5245534554;
   localparam logic [15:0] plain_size = 16'h0000;
   localparam logic [15:0] plain_read_level = 16'h000f;
   localparam logic [15:0] plain_write_level = 16'h0000;
   localparam logic [15:0] plain_time_overrun = 16'h00ff;
   localparam logic [15:0] plain_data_type = 16'h0001;
   // qualifiers of the factory reset resource
   localparam logic [63:0] factory_reset_resource_label = 64'h53485f4641435345;
   localparam logic [15:0] factory_size = 16'h0008;
   localparam logic [15:0] factory_read_level = 16'h000f;
   localparam logic [15:0] factory_write_level_q = 16'h0002;
   localparam logic [15:0] factory_time_overrun = 16'h00ff;
   localparam logic [15:0] factory_data_type = 16'h000b;

   typedef enum logic [1:0] {
      op_direct_read,
      op_direct_write,
      op_indirect_read,
      op_indirect_write
   } op_e;

   typedef struct packed {
      logic [11:0] resource_identifier;
      op_e op;
      logic [14:0] offset;
      logic [3:0] length;
      logic [3:0] access_level;
      logic [63:0] data;
   } request_s;

   typedef struct packed {
      logic valid;
      logic error;
      logic [15:0] error_code;
      logic [3:0] length;
      logic [63:0] data;
   } response_s;
endpackage

// file: rtl/reset_qualifier_rom.sv
// Purpose: qualifier lookup for the two reset resources
// Assumes: selector is the low offset bits of a direct read
// Notes: purely combinational; out-of-range selector flagged
`timescale 1ns/100ps
module reset_qualifier_rom (
   input wire logic factory,
   input wire logic [6:0] sel,
   output logic [63:0] value,
   output logic [3:0] length,
   output logic in_range
);
   logic [63:0] label;
   logic [15:0] size_q;
   logic [15:0] rd_lvl;
   logic [15:0] wr_lvl;
   logic [15:0] t_over;
   logic [15:0] d_type;

   // pick the resource's qualifier set
   assign label = factory ? reset_res_pkg::factory_reset_resource_label : reset_res_pkg::plain_reset_resource_label;
   assign size_q = factory ? reset_res_pkg::factory_size : reset_res_pkg::plain_size;
   assign rd_lvl = factory ? reset_res_pkg::factory_read_level : reset_res_pkg::plain_read_level;
   assign wr_lvl = factory ? reset_res_pkg::factory_write_level_q : reset_res_pkg::plain_write_level;
   assign t_over = factory ? reset_res_pkg::factory_time_overrun : reset_res_pkg::plain_time_overrun;
   assign d_type = factory ? reset_res_pkg::factory_data_type : reset_res_pkg::plain_data_type;
   assign in_range = sel < reset_res_pkg::qual_count;
   // name is 8 bytes, all others 2 bytes in the low word
   assign length = (sel == 7'h00) ? 4'h8 : 4'h2;
   assign value = (sel == 7'h00) ? label :
                  (sel == 7'h01) ? {48'h0, size_q} :
                  (sel == 7'h02) ? {48'h0, rd_lvl} :
                  (sel == 7'h03) ? {48'h0, wr_lvl} :
                  (sel == 7'h04) ? {48'h0, t_over} :
                  (sel == 7'h05) ? {48'h0, d_type} : 64'h0;
endmodule

// file: rtl/hub_reset_resource_handler.sv
// Purpose: serves the plain reset and factory reset resources of the sensor hub
// Assumes: req_valid is a one-cycle strobe with request fields stable in that cycle
// Notes: answers come one cycle after the strobe; reset pulses last one cycle
//
// What this block does
// - a device reset command 100h also pulses the hub reset
// - direct read selects qualifier 0..5 by low seven offset bits, else 13 40
// - direct write to either resource is refused with 14 41
// - indirect read of either resource is refused with 11 41
// - zero-length indirect write to plain reset starts a hub reset with no response data
// - plain reset indirect write ignores the offset entirely
// - factory reset restores input port parameters and error log to factory values
// - factory qualifiers: size 8, read 15, write 2, overrun 255, type 0Bh
// - eight-byte code word at level two or more resets, lower level gives 12 41
// - plain reset runs the power-on sequence, answered with an accepted zero-length response
`timescale 1ns/100ps
module hub_reset_resource_handler (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic req_valid,
   input wire reset_res_pkg::request_s req,
   output reset_res_pkg::response_s rsp,
   output logic hub_reset,
   output logic factory_restore
);
   // true when the request names the given resource
   function automatic logic id_is(input logic [11:0] id, input logic [11:0] ref_id);
      return id == ref_id;
   endfunction

   // true when the request carries the given transaction kind
   function automatic logic op_is(input reset_res_pkg::op_e op, input reset_res_pkg::op_e kind);
      return op == kind;
   endfunction

   // accepted answer carrying data, none for a trigger
   function automatic reset_res_pkg::response_s data_answer(input logic [3:0] len, input logic [63:0] value);
      reset_res_pkg::response_s a;
      a = '0;
      a.valid = 1'b1;
      a.length = len;
      a.data = value;
      return a;
   endfunction

   // refused answer carrying only the error code
   function automatic reset_res_pkg::response_s error_answer(input logic [15:0] code);
      reset_res_pkg::response_s a;
      a = '0;
      a.valid = 1'b1;
      a.error = 1'b1;
      a.error_code = code;
      return a;
   endfunction

   // request decode
   logic is_plain;
   logic is_factory;
   logic is_device_reset;
   logic served;
   logic is_direct_read;
   logic is_direct_write;
   logic is_indirect_read;
   logic is_indirect_write;

   // qualifier lookup
   logic [6:0] qual_sel;
   logic [63:0] qual_value;
   logic [3:0] qual_length;
   logic qual_in_range;

   // write checks
   logic plain_length_ok;
   logic factory_length_ok;
   logic word_match;
   logic code_match;
   logic level_ok;

   // actions taken this cycle
   logic do_plain;
   logic do_factory;
   logic do_device;
   logic next_hub_reset;
   logic next_factory_restore;

   // candidate answers, one per outcome
   reset_res_pkg::response_s idle_answer;
   reset_res_pkg::response_s qualifier_answer;
   reset_res_pkg::response_s bad_offset_answer;
   reset_res_pkg::response_s direct_write_answer;
   reset_res_pkg::response_s indirect_read_answer;
   reset_res_pkg::response_s done_answer;
   reset_res_pkg::response_s bad_data_answer;
   reset_res_pkg::response_s low_level_answer;

   // answers narrowed by transaction kind
   reset_res_pkg::response_s read_answer;
   reset_res_pkg::response_s plain_write_answer;
   reset_res_pkg::response_s factory_write_answer;
   reset_res_pkg::response_s write_answer;
   reset_res_pkg::response_s op_answer;
   reset_res_pkg::response_s next_rsp;

   // resource decode
   assign is_plain = id_is(req.resource_identifier, reset_res_pkg::plain_reset_id);
   assign is_factory = id_is(req.resource_identifier, reset_res_pkg::factory_reset_id);
   assign is_device_reset = id_is(req.resource_identifier, reset_res_pkg::device_reset_id);
   assign served = req_valid && (is_plain || is_factory);

   // transaction kind decode
   assign is_direct_read = op_is(req.op, reset_res_pkg::op_direct_read);
   assign is_direct_write = op_is(req.op, reset_res_pkg::op_direct_write);
   assign is_indirect_read = op_is(req.op, reset_res_pkg::op_indirect_read);
   assign is_indirect_write = op_is(req.op, reset_res_pkg::op_indirect_write);

   // low offset bits select, upper bits reserved
   assign qual_sel = req.offset[reset_res_pkg::offset_sel_width-1:0];
   reset_qualifier_rom qualifier_rom (
      .factory(is_factory),
      .sel(qual_sel),
      .value(qual_value),
      .length(qual_length),
      .in_range(qual_in_range)
   );

   assign plain_length_ok = req.length == 4'h0;

   assign factory_length_ok = req.length == 4'h8;
   assign word_match = req.data == reset_res_pkg::factory_reset_code_word;
   assign code_match = factory_length_ok && word_match;

   assign level_ok = req.access_level >= reset_res_pkg::factory_write_level;

   assign do_plain = served && is_plain && is_indirect_write && plain_length_ok;

   assign do_factory = served && is_factory && is_indirect_write && code_match && level_ok;

   assign do_device = req_valid && is_device_reset;

   // nothing shown outside an answer
   assign idle_answer = '0;

   assign qualifier_answer = data_answer(qual_length, qual_value);

   assign bad_offset_answer = error_answer(reset_res_pkg::err_bad_offset);

   assign direct_write_answer = error_answer(reset_res_pkg::err_no_direct_write);

   assign indirect_read_answer = error_answer(reset_res_pkg::err_no_indirect_read);

   assign done_answer = data_answer(4'h0, 64'h0);

   assign bad_data_answer = error_answer(reset_res_pkg::err_bad_data);

   assign low_level_answer = error_answer(reset_res_pkg::err_low_level);

   assign read_answer = qual_in_range ? qualifier_answer : bad_offset_answer;

   assign plain_write_answer = plain_length_ok ? done_answer : bad_data_answer;

   // data is checked before the level
   assign factory_write_answer = !code_match ? bad_data_answer :
                                 !level_ok ? low_level_answer : done_answer;

   // each resource keeps its own write outcome
   assign write_answer = is_plain ? plain_write_answer : factory_write_answer;

   // answer by transaction kind
   assign op_answer = is_direct_read ? read_answer :
                      is_direct_write ? direct_write_answer :
                      is_indirect_read ? indirect_read_answer : write_answer;

   // only the two served resources answer
   assign next_rsp = served ? op_answer : idle_answer;

   assign next_hub_reset = do_plain || do_device;

   assign next_factory_restore = do_factory;

   // registered answer, one cycle wide
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rsp <= '0;
      end else begin
         rsp <= next_rsp;
      end
   end

   // hub reset pulse, one cycle wide
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         hub_reset <= 1'b0;
      end else begin
         hub_reset <= next_hub_reset;
      end
   end

   // factory restore pulse, one cycle wide
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         factory_restore <= 1'b0;
      end else begin
         factory_restore <= next_factory_restore;
      end
   end
endmodule

// file: verif/hub_reset_chk.sv
// Purpose: port-level checks of the hub reset resource handler
// Assumes: answer and pulses come one cycle after the strobe
// Notes: bound onto the handler below its endmodule
`timescale 1ns/100ps
module hub_reset_chk (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic req_valid,
   input wire reset_res_pkg::request_s req,
   input wire reset_res_pkg::response_s rsp,
   input wire logic hub_reset,
   input wire logic factory_restore
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   // request decode
   wire logic pl = req_valid && req.resource_identifier == 12'h210;
   wire logic fa = req_valid && req.resource_identifier == 12'h218;
   wire logic word = fa && req.op == 2'h3 && req.length == 4'h8 && req.data == 64'h5245534554414c4c;
   sequence op_s(logic [1:0] o);
      (pl || fa) && req.op == o;
   endsequence
   sequence err_s(logic [15:0] c);
      rsp.valid && rsp.error && rsp.error_code == c;
   endsequence
   answer_next_a: assert property (pl || fa |=> rsp.valid) else $error("no answer");
   dev_reset_a: assert property (req_valid && req.resource_identifier == 12'h100 |=> hub_reset)
      else $error("no hub reset");
   bad_offset_a: assert property (op_s(2'h0) ##0 req.offset[6:0] > 7'h05 |=> err_s(16'h1340))
      else $error("offset");
   direct_write_a: assert property (op_s(2'h1) |=> err_s(16'h1441) ##0 !hub_reset) else $error("write");
   ind_read_a: assert property (op_s(2'h2) |=> err_s(16'h1141)) else $error("read");
   plain_go_a: assert property (op_s(2'h3) ##0 pl && req.length == 4'h0 |=> hub_reset && !rsp.error)
      else $error("plain");
   factory_go_a: assert property (word && req.access_level > 4'h1 |=> factory_restore && !rsp.error)
      else $error("factory");
   low_level_a: assert property (word && req.access_level < 4'h2 |=> err_s(16'h1241) ##0 !factory_restore)
      else $error("level");
   restore_cause_a: assert property (factory_restore |-> $past(word && req.access_level > 4'h1))
      else $error("restore");
endmodule
bind hub_reset_resource_handler hub_reset_chk chk (.clk_sys(clk_sys), .rst(rst), .req_valid(req_valid),
   .req(req), .rsp(rsp), .hub_reset(hub_reset), .factory_restore(factory_restore));

// file: verif/servo_requester.sv
// Purpose: servo drive side request model
// Assumes: send is entered at a falling edge
// Notes: fields are inverted once the strobe drops, so stale values never look held
`timescale 1ns/100ps
module servo_requester (
   input wire logic clk_sys,
   output logic req_valid,
   output reset_res_pkg::request_s req
);
   initial begin
      req_valid = 1'b0;
      req = '0;
   end
   task automatic send(input reset_res_pkg::request_s q);
      req <= q;
      req_valid <= 1'b1;
      @(negedge clk_sys);
      req_valid <= 1'b0;
      req <= ~q;
   endtask
endmodule

// file: verif/tb_hub_reset_resource_handler.sv
// Purpose: self-checking bench for the hub reset resource handler
// Assumes: answer and pulses one cycle after the strobe
// Notes: corner table first, then seeded random traffic
`timescale 1ns/100ps
module tb_hub_reset_resource_handler;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic req_valid;
   logic hub_reset;
   logic factory_restore;
   logic [11:0] ids [4] = '{12'h100, 12'h210, 12'h218, 12'h211};
   reset_res_pkg::request_s req;
   reset_res_pkg::request_s r;
   reset_res_pkg::response_s rsp;
   int errors = 0;
   int samples_checked = 0;
   always #5 clk_sys = ~clk_sys;
   servo_requester drv (.clk_sys(clk_sys), .req_valid(req_valid), .req(req));
   hub_reset_resource_handler dut (.clk_sys(clk_sys), .rst(rst), .req_valid(req_valid), .req(req), .rsp(rsp),
      .hub_reset(hub_reset), .factory_restore(factory_restore));
   // qualifier value by selector
   function automatic logic [63:0] qual(input logic f, input logic [2:0] s);
      logic [63:0] t [6];
      t = '{f ? reset_res_pkg::factory_reset_resource_label : reset_res_pkg::plain_reset_resource_label,
         f ? 64'h8 : 64'h0, 64'hf, f ? 64'h2 : 64'h0, 64'hff, f ? 64'hb : 64'h1};
      return t[s];
   endfunction
   // expected hub and factory pulses
   function automatic logic [1:0] pulses(input reset_res_pkg::request_s q);
      logic w;
      w = q.op == 2'h3;
      pulses[1] = q.resource_identifier == 12'h100 || (w && q.resource_identifier == 12'h210 && q.length == 4'h0);
      pulses[0] = w && q.resource_identifier == 12'h218 && q.length == 4'h8 && q.data == 64'h5245534554414c4c
         && q.access_level > 4'h1;
   endfunction
   // expected answer
   function automatic reset_res_pkg::response_s exp_rsp(input reset_res_pkg::request_s q);
      logic f;
      f = q.resource_identifier == 12'h218;
      exp_rsp = '0;
      exp_rsp.error = 1'b1;
      if (q.op == 2'h0 && q.offset[6:0] < 7'h06)
         exp_rsp = {2'b10, 16'h0, q.offset[6:0] == 7'h0 ? 4'h8 : 4'h2, qual(f, q.offset[2:0])};
      else if (q.op == 2'h0)
         exp_rsp.error_code = 16'h1340;
      else if (q.op != 2'h3)
         exp_rsp.error_code = q.op == 2'h1 ? 16'h1441 : 16'h1141;
      else if (pulses(q) != 2'b00)
         exp_rsp.error = 1'b0;
      else
         exp_rsp.error_code = f && q.length == 4'h8 && q.data == 64'h5245534554414c4c ? 16'h1241 : 16'h1441;
      exp_rsp.valid = f || q.resource_identifier == 12'h210;
      if (!exp_rsp.valid)
         exp_rsp = '0;
   endfunction
   // response compare over every field, unused fields must read zero
   task automatic chk_rsp(input reset_res_pkg::response_s e);
      samples_checked++;
      if (rsp !== e) begin
         errors++;
         $display("Error at %0t: rsp %h not %h", $time, rsp, e);
      end
   endtask
   task automatic chk_pulse(input logic [1:0] e);
      samples_checked++;
      if ({hub_reset, factory_restore} !== e) begin
         errors++;
         $display("Error at %0t: pulses %b not %b", $time, {hub_reset, factory_restore}, e);
      end
   endtask
   // idle check, strobe, then answer check
   task automatic run(input reset_res_pkg::request_s q);
      @(negedge clk_sys);
      chk_rsp('0);
      chk_pulse(2'b00);
      drv.send(q);
      chk_rsp(exp_rsp(q));
      chk_pulse(pulses(q));
   endtask
   task automatic final_report();
      $display("checked %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial begin
      void'($urandom(90));
      repeat (2) @(negedge clk_sys);
      rst = 1'b0;
      // every op, selector 0..6 and level 0..6 on both resources
      for (int k = 0; k < 56; k++) begin
         r = 101'({$urandom, $urandom, $urandom, $urandom});
         r.resource_identifier = k[0] ? 12'h218 : 12'h210;
         r.op = reset_res_pkg::op_e'(k[2:1]);
         r.offset[6:0] = 7'(k / 8);
         r.access_level = 4'(k / 8);
         r.length = {k[0], 3'h0};
         r.data = 64'h5245534554414c4c;
         run(r);
      end
      // random traffic with exact and one-bit-off code words
      repeat (300) begin
         r = 101'({$urandom, $urandom, $urandom, $urandom});
         r.resource_identifier = ids[$urandom_range(3)];
         if ($urandom_range(1))
            r.data = 64'h5245534554414c4c ^ (64'($urandom_range(1)) << $urandom_range(63));
         if ($urandom_range(1))
            r.length = {r.length[0], 3'h0};
         run(r);
      end
      final_report();
   end
endmodule
